// file: dbr_assertions.sv
`timescale 1ns/1ps
module dbr_checker
    import dbr_pkg::*;
(
    // Core side
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        idr_tick,
    input wire dbr_sample_t idr_data,
    input wire logic        conv_tick,
    input wire logic        odr_tick,
    input wire dbr_sample_t odr_data,
    input wire logic [4:0]  buf_level,
    // Link side
    input wire logic        link_clk,
    input wire logic        link_start,
    input wire logic [7:0]  link_addr,
    input wire logic        link_wr,
    input wire logic        link_rd,
    input wire logic [7:0]  link_rdata,
    input wire logic [7:0]  link_ptr,
    input wire logic        link_sample_ok
);
    wire step = (link_rd | link_wr) & ~link_start;
    // Link side leaves reset several link edges late
    logic [3:0] lr;
    always_ff @(posedge link_clk) begin
        lr <= {lr[2:0], reset};
    end
    wire link_busy = reset | (|lr);
    // --------------------------------
    // Core rate
    // --------------------------------
    property p_conv;
        @(posedge mclk) disable iff (reset) idr_tick |=> conv_tick;
    endproperty
    a_conv: assert property (p_conv) else $error("conv tick missing");
    property p_odr_src;
        @(posedge mclk) disable iff (reset) odr_tick |-> $past(idr_tick) && odr_data == $past(idr_data);
    endproperty
    a_odr_src: assert property (p_odr_src) else $error("odr sample wrong");
    property p_odr_hold;
        @(posedge mclk) disable iff (reset) !odr_tick |-> $stable(odr_data);
    endproperty
    a_odr_hold: assert property (p_odr_hold) else $error("odr data moved");
    property p_level;
        @(posedge mclk) disable iff (reset) 1'b1 |=> buf_level <= 5'h10 && buf_level - $past(buf_level) + 5'h01 <= 5'h02;
    endproperty
    a_level: assert property (p_level) else $error("buffer level jump");
    // --------------------------------
    // Link pointer
    // --------------------------------
    property p_start;
        @(posedge link_clk) disable iff (link_busy) link_start |=> link_ptr == $past(link_addr);
    endproperty
    a_start: assert property (p_start) else $error("pointer not loaded");
    property p_wrap12;
        @(posedge link_clk) disable iff (link_busy) step && link_ptr == 8'h12 |=> link_ptr inside {8'h0D, 8'h13};
    endproperty
    a_wrap12: assert property (p_wrap12) else $error("bad step at z high");
    property p_wrap14;
        @(posedge link_clk) disable iff (link_busy) step && link_ptr == 8'h14 |=> link_ptr inside {8'h0D, 8'h15};
    endproperty
    a_wrap14: assert property (p_wrap14) else $error("bad step at flags");
    property p_inc;
        @(posedge link_clk) disable iff (link_busy)
            step && !(link_ptr inside {8'h12, 8'h14}) |=> link_ptr == $past(link_ptr) + 8'h01;
        // link-side reset guard applies above
    endproperty
    a_inc: assert property (p_inc) else $error("pointer not advanced");
    property p_fetch;
        @(posedge link_clk) disable iff (link_busy) link_start && link_addr == 8'h0D |=> !link_sample_ok;
    endproperty
    a_fetch: assert property (p_fetch) else $error("stale sample flag");
    property p_rdata;
        @(posedge link_clk) disable iff (link_busy) !link_rd |=> $stable(link_rdata);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read byte moved");
    c_odr: cover property (@(posedge mclk) odr_tick);
    c_full: cover property (@(posedge mclk) buf_level == 5'h10);
    c_ok: cover property (@(posedge link_clk) $rose(link_sample_ok));
endmodule

// file: dbr_cfg.svh
`ifndef DBR_CFG_SVH
`define DBR_CFG_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define DBR_REG_CTRL      8'h30
`define DBR_CTRL_RESET    8'h00
`define DBR_ADDR_X_LOW    8'h0D
`define DBR_ADDR_Z_HIGH   8'h12
`define DBR_ADDR_INTR     8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DBR_RATE_MSB      3
`define DBR_RATE_LSB      0
`define DBR_LINEAR_BIT    4
`define DBR_WRAPSEL_BIT   5
`define DBR_RESV_BIT      6
`define DBR_BURST_BIT     7

// ----------------------------------------
// Divisors per code
// ----------------------------------------
`define DBR_DIV_1         10'h002
`define DBR_DIV_2         10'h004
`define DBR_DIV_3         10'h005
`define DBR_DIV_4         10'h008
`define DBR_DIV_5         10'h00A
`define DBR_DIV_6         10'h010
`define DBR_DIV_7         10'h014
`define DBR_DIV_8         10'h028
`define DBR_DIV_9         10'h043
`define DBR_DIV_A         10'h050
`define DBR_DIV_B         10'h064
`define DBR_DIV_C         10'h0C8
`define DBR_DIV_D         10'h0FA
`define DBR_DIV_E         10'h1F4
`define DBR_DIV_F         10'h3E8

// ----------------------------------------
// Sizes
// ----------------------------------------
`define DBR_SAMPLE_W      48
`define DBR_SAMPLE_BYTES  6
`define DBR_BURST_MAX     6'h20
`define DBR_FIFO_DEPTH    16

`endif

// file: dbr_fifo.sv
`timescale 1ns/1ps
module dbr_fifo #(
    parameter int W = 48,
    parameter int D = 16
) (
    // System
    input  wire logic           clk,
    input  wire logic           rst,
    // Streams
    dbr_stream_if.snk           in_s,
    dbr_stream_if.src           out_s,
    // Status
    output logic [$clog2(D):0]  level
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW:0]  wr_ptr;
    logic [AW:0]  rd_ptr;
    logic         full;
    logic         empty;
    logic         do_wr;
    logic         do_rd;

    assign full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty = (wr_ptr == rd_ptr);
    assign do_wr = in_s.valid && !full;
    assign do_rd = out_s.ready && !empty;
    assign in_s.ready  = !full;
    assign out_s.valid = !empty;
    assign out_s.data  = mem[rd_ptr[AW-1:0]];
    assign level = wr_ptr - rd_ptr;

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr[AW-1:0]] <= in_s.data;
        end
    end

    // ----------------------------------------
    // Pointers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
        end else if (do_wr) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_ptr <= '0;
        end else if (do_rd) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule

// file: dbr_host.sv
`timescale 1ns/1ps
module dbr_host (
    // Link pins
    output logic       link_clk,
    output logic       link_start,
    output logic [7:0] link_addr,
    output logic       link_wr,
    output logic [7:0] link_wdata,
    output logic       link_rd,
    output logic [5:0] read_count,
    input  wire logic  link_sample_ok
);
    logic run = 1'b1;
    initial begin
        link_clk = 1'b0;
        link_start = 1'b0;
        link_addr = 8'h00;
        link_wr = 1'b0;
        link_wdata = 8'h00;
        link_rd = 1'b0;
        read_count = 6'h00;
    end
    // Clock stops low between frames
    initial begin
        #3.3;
        forever begin
            #15;
            if (run || link_clk) begin
                link_clk = ~link_clk;
            end
        end
    end
    task automatic tick;
        @(posedge link_clk);
        #1;
    endtask
    task automatic begin_frame;
        run = 1'b1;
        repeat (4) tick();
    endtask
    task automatic end_frame;
        repeat (8) tick();
        run = 1'b0;
    endtask
    task automatic start(input logic [7:0] a);
        link_start = 1'b1;
        link_addr = a;
        tick();
        link_start = 1'b0;
        link_addr = ~a;
    endtask
    task automatic write(input logic [7:0] d);
        link_wr = 1'b1;
        link_wdata = d & 8'hBF;
        tick();
        link_wr = 1'b0;
        link_wdata = ~link_wdata;
    endtask
    task automatic read;
        link_rd = 1'b1;
        tick();
        link_rd = 1'b0;
    endtask
    task automatic wait_ok(output logic ok);
        ok = 1'b0;
        for (int i = 0; i < 300 && !ok; i++) begin
            tick();
            ok = (link_sample_ok === 1'b1);
        end
    endtask
    task automatic burst_setup(input logic [5:0] n);
        read_count = n;
        start(8'h30);
        write(8'h80);
    endtask
endmodule

// file: dbr_pkg.sv
package dbr_pkg;
`include "dbr_cfg.svh"

    typedef logic [`DBR_SAMPLE_W-1:0] dbr_sample_t;
    typedef logic [3:0]               dbr_rate_t;
    typedef logic [9:0]               dbr_div_t;
    typedef enum logic [0:0] {
        ST_IDLE,
        ST_WAIT
    } dbr_fetch_state_t;

endpackage

// file: dbr_stream_if.sv
`timescale 1ns/1ps
interface dbr_stream_if #(parameter int W = 48);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// file: dbr_top.sv
`timescale 1ns/1ps
module dbr_top
    import dbr_pkg::*;
(
    // System
    input  wire logic        mclk,
    input  wire logic        reset,
    // Internal sample stream
    input  wire logic        idr_tick,
    input  wire dbr_sample_t idr_data,
    // Converter and filter enable
    output logic             conv_tick,
    // Output-rate stream
    output logic             odr_tick,
    output dbr_sample_t      odr_data,
    // Buffer status
    output logic [4:0]       buf_level,
    output logic             buf_full,
    // Host link
    input  wire logic        link_clk,
    input  wire logic        link_start,
    input  wire logic [7:0]  link_addr,
    input  wire logic        link_wr,
    input  wire logic [7:0]  link_wdata,
    input  wire logic        link_rd,
    input  wire logic [5:0]  read_count,
    output logic [7:0]       link_rdata,
    output logic [7:0]       link_ptr,
    output logic             link_sample_ok
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [2:0]        lrst_s;
    logic              link_rst;
    logic [7:0]        ctrl;
    logic [7:0]        next_ptr;
    logic [7:0]        wrap_end;
    logic [5:0]        samp_done;
    logic [5:0]        burst_lim;
    dbr_sample_t       link_sample;
    logic              rq_t;
    logic [2:0]        ack_s;
    logic              ack_seen;
    logic              fetch_now;
    logic              burst_next;
    dbr_rate_t         rt_data;
    logic              rt_t;
    logic [2:0]        rtack_s;
    logic              rtack_seen;
    logic [2:0]        rq_s;
    logic              rq_seen;
    logic              ack_t;
    dbr_sample_t       hold;
    dbr_fetch_state_t  fstate;
    logic [2:0]        rt_s;
    logic              rt_seen;
    logic              rtack_t;
    dbr_rate_t         rate_m;
    dbr_rate_t         rate_prev;
    dbr_div_t          div;
    dbr_div_t          cnt;
    logic              pend;
    dbr_sample_t       pend_data;
    logic [4:0]        lvl;

    dbr_stream_if #(.W(`DBR_SAMPLE_W)) push_s ();
    dbr_stream_if #(.W(`DBR_SAMPLE_W)) pop_s ();

    // ----------------------------------------
    // Divisor lookup
    // ----------------------------------------
    function automatic dbr_div_t divisor(input dbr_rate_t code);
        case (code)
            4'h1:    divisor = `DBR_DIV_1;
            4'h2:    divisor = `DBR_DIV_2;
            4'h3:    divisor = `DBR_DIV_3;
            4'h4:    divisor = `DBR_DIV_4;
            4'h5:    divisor = `DBR_DIV_5;
            4'h6:    divisor = `DBR_DIV_6;
            4'h7:    divisor = `DBR_DIV_7;
            4'h8:    divisor = `DBR_DIV_8;
            4'h9:    divisor = `DBR_DIV_9;
            4'hA:    divisor = `DBR_DIV_A;
            4'hB:    divisor = `DBR_DIV_B;
            4'hC:    divisor = `DBR_DIV_C;
            4'hD:    divisor = `DBR_DIV_D;
            4'hE:    divisor = `DBR_DIV_E;
            4'hF:    divisor = `DBR_DIV_F;
            default: divisor = 10'h001;
        endcase
    endfunction

    // ----------------------------------------
    // Link-side reset
    // ----------------------------------------
    always_ff @(posedge link_clk) begin
        lrst_s <= {lrst_s[1:0], reset};
    end

    always_ff @(posedge link_clk) begin
        if (lrst_s[1] == lrst_s[2]) begin
            link_rst <= lrst_s[2];
        end
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            ctrl <= `DBR_CTRL_RESET;
        end else if (link_wr && !link_start && link_ptr == `DBR_REG_CTRL) begin
            ctrl <= link_wdata;
        end
    end

    // ----------------------------------------
    // Address pointer
    // ----------------------------------------
    always_comb begin
        wrap_end = ctrl[`DBR_WRAPSEL_BIT] ? `DBR_ADDR_INTR : `DBR_ADDR_Z_HIGH;
        if (!ctrl[`DBR_LINEAR_BIT] && link_ptr == wrap_end) begin
            next_ptr = `DBR_ADDR_X_LOW;
        end else begin
            next_ptr = link_ptr + 8'h01;
        end
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            link_ptr <= 8'h00;
        end else if (link_start) begin
            link_ptr <= link_addr;
        end else if (link_rd || link_wr) begin
            link_ptr <= next_ptr;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            link_rdata <= 8'h00;
        end else if (link_rd && !link_start) begin
            case (link_ptr)
                `DBR_REG_CTRL: link_rdata <= ctrl;
                8'h0D:         link_rdata <= link_sample[7:0];
                8'h0E:         link_rdata <= link_sample[15:8];
                8'h0F:         link_rdata <= link_sample[23:16];
                8'h10:         link_rdata <= link_sample[31:24];
                8'h11:         link_rdata <= link_sample[39:32];
                8'h12:         link_rdata <= link_sample[47:40];
                default:       link_rdata <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // Sample fetch requests
    // ----------------------------------------
    assign burst_lim  = (read_count > `DBR_BURST_MAX) ? `DBR_BURST_MAX : read_count;
    assign burst_next = ctrl[`DBR_BURST_BIT]
                      && (samp_done + 6'h01 < burst_lim);
    assign fetch_now  = (link_start && link_addr == `DBR_ADDR_X_LOW)
                      || (!link_start && link_rd && link_ptr == `DBR_ADDR_Z_HIGH
                          && burst_next);

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            samp_done <= 6'h00;
        end else if (link_start) begin
            samp_done <= 6'h00;
        end else if (link_rd && link_ptr == `DBR_ADDR_Z_HIGH && samp_done != 6'h3F) begin
            samp_done <= samp_done + 6'h01;
        end
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            rq_t <= 1'b0;
        end else if (fetch_now) begin
            rq_t <= ~rq_t;
        end
    end

    always_ff @(posedge link_clk) begin
        ack_s <= {ack_s[1:0], ack_t};
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            ack_seen <= 1'b0;
        end else if (ack_s[1] == ack_s[2]) begin
            ack_seen <= ack_s[2];
        end
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            link_sample    <= '0;
            link_sample_ok <= 1'b0;
        end else if (fetch_now) begin
            link_sample_ok <= 1'b0;
        end else if (ack_seen != rq_t && ack_s[1] == ack_s[2] && ack_s[2] == rq_t) begin
            link_sample    <= hold;
            link_sample_ok <= 1'b1;
        end
    end

    // ----------------------------------------
    // Rate field hand-off to core clock
    // ----------------------------------------
    always_ff @(posedge link_clk) begin
        rtack_s <= {rtack_s[1:0], rtack_t};
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            rtack_seen <= 1'b0;
        end else if (rtack_s[1] == rtack_s[2]) begin
            rtack_seen <= rtack_s[2];
        end
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            rt_data <= 4'h0;
            rt_t    <= 1'b0;
        end else if (rtack_seen == rt_t && rt_data != ctrl[`DBR_RATE_MSB:`DBR_RATE_LSB]) begin
            rt_data <= ctrl[`DBR_RATE_MSB:`DBR_RATE_LSB];
            rt_t    <= ~rt_t;
        end
    end

    always_ff @(posedge mclk) begin
        rt_s <= {rt_s[1:0], rt_t};
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rt_seen <= 1'b0;
            rtack_t <= 1'b0;
            rate_m  <= 4'h0;
        end else if (rt_s[1] == rt_s[2] && rt_s[2] != rt_seen) begin
            rt_seen <= rt_s[2];
            rtack_t <= rt_s[2];
            rate_m  <= rt_data;
        end
    end

    // ----------------------------------------
    // Decimator
    // ----------------------------------------
    assign div = divisor(rate_m);

    always_ff @(posedge mclk) begin
        if (reset) begin
            conv_tick <= 1'b0;
        end else begin
            conv_tick <= idr_tick;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rate_prev <= 4'h0;
        end else begin
            rate_prev <= rate_m;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt <= 10'h000;
        end else if (rate_m != rate_prev) begin
            cnt <= 10'h000;
        end else if (idr_tick) begin
            cnt <= (cnt >= div - 10'h001) ? 10'h000 : cnt + 10'h001;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            odr_tick <= 1'b0;
            odr_data <= '0;
        end else begin
            odr_tick <= idr_tick && rate_m == rate_prev
                     && cnt >= div - 10'h001;
            if (idr_tick && rate_m == rate_prev && cnt >= div - 10'h001) begin
                odr_data <= idr_data;
            end
        end
    end

    // ----------------------------------------
    // Buffer fill with back-pressure
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            pend      <= 1'b0;
            pend_data <= '0;
        end else if (odr_tick && (!pend || push_s.ready)) begin
            pend      <= 1'b1;
            pend_data <= odr_data;
        end else if (push_s.ready) begin
            pend      <= 1'b0;
        end
    end

    assign push_s.valid = pend;
    assign push_s.data  = pend_data;

    dbr_fifo #(
        .W (`DBR_SAMPLE_W),
        .D (`DBR_FIFO_DEPTH)
    ) u_fifo (
        .clk   (mclk),
        .rst   (reset),
        .in_s  (push_s.snk),
        .out_s (pop_s.src),
        .level (lvl)
    );

    always_ff @(posedge mclk) begin
        if (reset) begin
            buf_level <= 5'h00;
            buf_full  <= 1'b0;
        end else begin
            buf_level <= lvl;
            buf_full  <= !push_s.ready;
        end
    end

    // ----------------------------------------
    // Buffer drain toward link
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        rq_s <= {rq_s[1:0], rq_t};
    end

    assign pop_s.ready = (fstate == ST_WAIT) && pop_s.valid;

    always_ff @(posedge mclk) begin
        if (reset) begin
            rq_seen <= 1'b0;
            fstate  <= ST_IDLE;
        end else begin
            case (fstate)
                ST_IDLE: begin
                    if (rq_s[1] == rq_s[2] && rq_s[2] != rq_seen) begin
                        rq_seen <= rq_s[2];
                        fstate  <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (pop_s.valid) begin
                        fstate <= ST_IDLE;
                    end
                end
                default: fstate <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            hold  <= '0;
            ack_t <= 1'b0;
        end else if (pop_s.ready) begin
            hold  <= pop_s.data;
            ack_t <= rq_seen;
        end
    end

endmodule

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
    import dbr_pkg::*;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic        idr_tick = 1'b0;
    dbr_sample_t idr_data = '0;
    logic        conv_tick, odr_tick, buf_full, link_clk, link_start, link_wr, link_rd, link_sample_ok;
    logic [7:0]  link_addr, link_wdata, link_rdata, link_ptr, v;
    logic [5:0]  read_count;
    logic [4:0]  buf_level;
    dbr_sample_t odr_data, last;
    dbr_sample_t odr_q[$], buf_q[$];
    logic [7:0]  byte_q[$];
    logic        rd_d = 1'b0;
    logic        ok;
    int          n_errors = 0, total_checks = 0, seed = 28, cyc = 0, cnt = 0, div = 1;
    localparam int DIVS [16] = '{1, 2, 4, 5, 8, 10, 16, 20, 40, 67, 80, 100, 200, 250, 500, 1000};
    localparam logic [7:0] WTAB [6][3] = '{'{8'h00, 8'h12, 8'h0D}, '{8'h20, 8'h12, 8'h13},
        '{8'h20, 8'h14, 8'h0D}, '{8'h10, 8'h12, 8'h13}, '{8'h10, 8'h14, 8'h15}, '{8'h30, 8'h14, 8'h15}};
    always #5 mclk = ~mclk;
    dbr_top u_dut (.mclk(mclk), .reset(reset), .idr_tick(idr_tick), .idr_data(idr_data),
        .conv_tick(conv_tick), .odr_tick(odr_tick), .odr_data(odr_data), .buf_level(buf_level),
        .buf_full(buf_full), .link_clk(link_clk), .link_start(link_start), .link_addr(link_addr),
        .link_wr(link_wr), .link_wdata(link_wdata), .link_rd(link_rd), .read_count(read_count),
        .link_rdata(link_rdata), .link_ptr(link_ptr), .link_sample_ok(link_sample_ok));
    dbr_host u_host (.link_clk(link_clk), .link_start(link_start), .link_addr(link_addr),
        .link_wr(link_wr), .link_wdata(link_wdata), .link_rd(link_rd), .read_count(read_count),
        .link_sample_ok(link_sample_ok));
    // --------------------------------
    // Checking
    // --------------------------------
    task automatic chk48(input dbr_sample_t e, input dbr_sample_t g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic chk8(input logic [7:0] e, input logic [7:0] g);
        chk48({40'h0, e}, {40'h0, g});
    endtask
    task automatic test_done;
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge link_clk) begin
        if (rd_d) begin
            chk8(byte_q.pop_front(), link_rdata);
        end
        rd_d <= link_rd;
    end
    always @(posedge mclk) begin
        cyc++;
        if (odr_tick === 1'b1) begin
            chk48(odr_q.pop_front(), odr_data);
        end
        if (cyc == 40000) begin
            n_errors++;
            test_done();
        end
    end
    // --------------------------------
    // Stimulus
    // --------------------------------
    task automatic rdx(input logic [7:0] e);
        byte_q.push_back(e);
        u_host.read();
    endtask
    task automatic send(input int n);
        for (int i = 0; i < n; i++) begin
            idr_tick = 1'b1;
            idr_data = dbr_sample_t'({$random(seed), $random(seed)});
            cnt++;
            if (cnt == div) begin
                cnt = 0;
                odr_q.push_back(idr_data);
                buf_q.push_back(idr_data);
            end
            @(posedge mclk);
            #1;
            idr_tick = 1'b0;
            repeat ({$random(seed)} % 3) begin
                @(posedge mclk);
                #1;
            end
        end
    endtask
    task automatic set_ctrl(input logic [7:0] c);
        u_host.begin_frame();
        u_host.start(8'h30);
        u_host.write(c);
        u_host.end_frame();
        repeat (20) @(posedge mclk);
        #1;
        cnt = 0;
        div = DIVS[c[3:0]];
    endtask
    task automatic do_reset;
        u_host.run = 1'b1;
        reset = 1'b1;
        repeat (16) @(posedge mclk);
        #1;
        reset = 1'b0;
        odr_q.delete();
        buf_q.delete();
        cnt = 0;
        div = 1;
        u_host.begin_frame();
        u_host.start(8'h30);
        rdx(8'h00);
        u_host.end_frame();
    endtask
    initial begin
        do_reset();
        v = 8'($random(seed)) & 8'hBF;
        u_host.begin_frame();
        u_host.start(8'h30);
        u_host.write(v);
        u_host.write(8'h55);
        u_host.start(8'h30);
        rdx(v);
        rdx(8'h00);
        chk8(8'h32, link_ptr);
        u_host.end_frame();
        for (int c = 0; c < 16; c++) begin
            set_ctrl(8'(c));
            send(DIVS[c]);
            send(DIVS[c] / 2);
        end
        set_ctrl(8'h00);
        send(4);
        repeat (10) @(posedge mclk);
        #1;
        chk8(8'h10, 8'(buf_level));
        chk8(8'h01, 8'(buf_full));
        u_host.begin_frame();
        u_host.burst_setup(6'd16);
        u_host.start(8'h0D);
        for (int s = 0; s < 16; s++) begin
            u_host.wait_ok(ok);
            chk8(8'h01, 8'(ok));
            last = buf_q.pop_front();
            for (int b = 0; b < 6; b++) begin
                rdx(last[8*b +: 8]);
            end
            chk8(8'h0D, link_ptr);
        end
        u_host.end_frame();
        for (int i = 0; i < 6; i++) begin
            u_host.begin_frame();
            u_host.start(8'h30);
            u_host.write(WTAB[i][0]);
            u_host.start(WTAB[i][1]);
            rdx(WTAB[i][1] == 8'h12 ? last[47:40] : 8'h00);
            chk8(WTAB[i][2], link_ptr);
            u_host.end_frame();
        end
        do_reset();
        send(3);
        repeat (10) @(posedge mclk);
        chk8(8'h00, 8'(odr_q.size()));
        test_done();
    end
endmodule
bind dbr_top dbr_checker u_chk (.mclk(mclk), .reset(reset), .idr_tick(idr_tick), .idr_data(idr_data),
    .conv_tick(conv_tick), .odr_tick(odr_tick), .odr_data(odr_data), .buf_level(buf_level),
    .link_clk(link_clk), .link_start(link_start), .link_addr(link_addr), .link_wr(link_wr),
    .link_rd(link_rd), .link_rdata(link_rdata), .link_ptr(link_ptr), .link_sample_ok(link_sample_ok));
